// ==== core/omx_params.svh ====
`ifndef OMX_PARAMS_SVH
`define OMX_PARAMS_SVH

// register offsets on the index/data register port
`define OMX_OFF_OUT_CTRL 8'h08
`define OMX_OFF_EFFECT 8'h14
`define OMX_OFF_COLOR_BASE 8'h15
`define OMX_OFF_COLOR_LAST 8'h1D
`define OMX_OFF_STATUS 8'h30

// field positions
`define OMX_FMT_BIT 7
`define OMX_FX_LSB 0
`define OMX_FX_MSB 1

// reset values
`define OMX_RST_OUT_CTRL 8'h00
`define OMX_RST_EFFECT 8'h00
`define OMX_RST_COLOR 8'h00

// sizing
`define OMX_COLOR_BYTES 9
`define OMX_FIFO_DEPTH 32

`endif

// ==== core/omx_pkg.sv ====
package omx_pkg;

  // how an active overlay code treats the source pixel
  typedef enum logic [1:0] {
    OMX_FX_REPLACE = 2'b00,
    OMX_FX_AND = 2'b01,
    OMX_FX_OR = 2'b10,
    OMX_FX_XOR = 2'b11
  } omx_effect_e;

  // digital pixel bus format
  typedef enum logic {
    OMX_FMT_RGB565 = 1'b0,
    OMX_FMT_YUV422 = 1'b1
  } omx_format_e;

  // source pixel: full 8-bit rgb plus the matching yuv422 sample
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] luma;
    logic [7:0] chroma;
    logic chroma_is_v;
  } omx_src_s;

  // word held in the output fifo
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] luma;
    logic [7:0] chroma;
    logic chroma_is_v;
    omx_format_e fmt;
  } omx_pix_s;

endpackage

// ==== core/omx_fifo.sv ====
module omx_fifo import omx_pkg::*; #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty without a separate counter
  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer advance
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage needs no reset; only valid slots are ever read out
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule // omx_fifo

// ==== core/omx_fmt.sv ====
module omx_fmt import omx_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire omx_pix_s in_pix,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data,
  output logic out_chroma_v
);
  logic next_valid;
  logic [15:0] next_data;
  logic next_chroma_v;
  logic take;

  // lane packing for the 16-bit digital bus
  function automatic logic [15:0] omx_pack(input omx_pix_s p);
    if (p.fmt == OMX_FMT_YUV422) begin
      omx_pack = {p.chroma, p.luma};
    end else begin
      omx_pack = {p.green[4:2], p.blue[7:3], p.red[7:3], p.green[7:5]};
    end
  endfunction

  // one output slot; it may refill in the cycle it is drained
  assign in_ready = !out_valid || out_ready;
  assign take = in_valid && in_ready;

  always_comb begin
    next_valid = out_valid;
    next_data = out_data;
    next_chroma_v = out_chroma_v;
    if (take) begin
      next_valid = 1'b1;
      next_data = omx_pack(in_pix);
      next_chroma_v = in_pix.chroma_is_v;
    end else if (out_ready) begin
      next_valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= 16'h0000;
      out_chroma_v <= 1'b0;
    end else begin
      out_valid <= next_valid;
      out_data <= next_data;
      out_chroma_v <= next_chroma_v;
    end
  end

  a_yuv_lanes: assert property (@(posedge clk) disable iff (sys_rst)
    take && in_pix.fmt == OMX_FMT_YUV422 |=> out_valid && out_data[7:0] == $past(in_pix.luma)
      && out_data[15:8] == $past(in_pix.chroma))
    else $error("yuv lanes wrong");

  a_rgb_lanes: assert property (@(posedge clk) disable iff (sys_rst)
    take && in_pix.fmt == OMX_FMT_RGB565 |=> out_data[7:3] == $past(in_pix.red[7:3])
      && out_data[2:0] == $past(in_pix.green[7:5]) && out_data[15:13] == $past(in_pix.green[4:2])
      && out_data[12:8] == $past(in_pix.blue[7:3]))
    else $error("rgb565 lanes wrong");

endmodule // omx_fmt

// ==== core/omx_mixer.sv ====
// Overview of operation
// - overlay code 00 passes the source pixel through unchanged.
// - codes 01, 10, 11 select overlay colour one, two, three for the pixel.
// - three host-written 24-bit colours live in registers 15h to 1Dh.
// - register 14h picks replace, AND, OR or XOR against the source.
// - XOR with an all-ones colour inverts every source colour bit.
// - overlay acts on the rgb output and never touches the yuv output.
// - a 16-bit digital pixel bus carries RGB565 or YUV422.
// - in yuv mode lines 7..0 carry luma, lines 15..8 alternating chroma.
// - rgb565 lanes: 7..3 red, 2..0 green high, 15..13 green low, 12..8 blue.
// - bit 7 of register 08h selects yuv422 when set, rgb565 when clear.
// - yuv output bypasses overlay, bitmap, lookup table and cropping.
// - rgb output bypasses lookup table and cropping but keeps overlay.
`include "omx_params.svh"

module omx_mixer import omx_pkg::*; #(
  parameter int FIFO_DEPTH = `OMX_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic src_valid,
  output logic src_ready,
  input wire omx_src_s src_pixel,
  input wire logic overlay_select_hi,
  input wire logic overlay_select_lo,
  output logic pixel_out_valid,
  input wire logic pixel_out_ready,
  output logic [15:0] pixel_out,
  output logic pixel_out_chroma_v,
  output logic digital_format_select
);
  localparam int PIXW = $bits(omx_pix_s);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [7:0] out_ctrl;
  logic [7:0] effect_sel;
  logic [7:0] color [`OMX_COLOR_BYTES];
  logic [1:0] last_code;
  logic [7:0] next_out_ctrl;
  logic [7:0] next_effect_sel;
  logic [7:0] next_color [`OMX_COLOR_BYTES];
  logic [1:0] next_last_code;
  logic [7:0] next_reg_rdata;

  logic [1:0] ovl_code;
  omx_effect_e effect;
  logic [23:0] sel_color;
  omx_pix_s fifo_in;
  omx_pix_s fifo_out;
  logic [PIXW-1:0] fifo_out_bits;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [LW-1:0] fifo_level;
  logic push;

  // true when an index falls in the overlay colour byte range
  function automatic logic omx_is_color(input logic [7:0] addr);
    omx_is_color = (addr >= `OMX_OFF_COLOR_BASE) && (addr <= `OMX_OFF_COLOR_LAST);
  endfunction

  // byte position inside the colour table
  function automatic logic [3:0] omx_color_idx(input logic [7:0] addr);
    omx_color_idx = 4'(addr - `OMX_OFF_COLOR_BASE);
  endfunction

  // one channel of the overlay effect, always at full 8 bits
  function automatic logic [7:0] omx_apply(input omx_effect_e fx, input logic [7:0] src,
                                           input logic [7:0] ovl);
    case (fx)
      OMX_FX_REPLACE: omx_apply = ovl;
      OMX_FX_AND: omx_apply = src & ovl;
      OMX_FX_OR: omx_apply = src | ovl;
      OMX_FX_XOR: omx_apply = src ^ ovl;
      default: omx_apply = ovl;
    endcase
  endfunction

  // the pins come from logic on this same pixel clock, so no synchroniser:
  // a sync stage would slide the overlay off its pixel
  assign ovl_code = {overlay_select_hi, overlay_select_lo};
  assign effect = omx_effect_e'(effect_sel[`OMX_FX_MSB:`OMX_FX_LSB]);
  assign digital_format_select = out_ctrl[`OMX_FMT_BIT];
  assign push = src_valid && fifo_in_ready;
  assign src_ready = fifo_in_ready; // fifo back-pressure stalls the source

  // colour chosen by the pin code; bytes run red, green, blue per colour
  always_comb begin
    case (ovl_code)
      2'b01: sel_color = {color[0], color[1], color[2]};
      2'b10: sel_color = {color[3], color[4], color[5]};
      2'b11: sel_color = {color[6], color[7], color[8]};
      default: sel_color = 24'h00_0000;
    endcase
  end

  // mix stage: rgb gets the overlay, yuv samples are carried untouched
  always_comb begin
    fifo_in.luma = src_pixel.luma;
    fifo_in.chroma = src_pixel.chroma;
    fifo_in.chroma_is_v = src_pixel.chroma_is_v;
    fifo_in.fmt = omx_format_e'(out_ctrl[`OMX_FMT_BIT]);
    if (ovl_code == 2'b00) begin
      fifo_in.red = src_pixel.red;
      fifo_in.green = src_pixel.green;
      fifo_in.blue = src_pixel.blue;
    end else begin
      fifo_in.red = omx_apply(effect, src_pixel.red, sel_color[23:16]);
      fifo_in.green = omx_apply(effect, src_pixel.green, sel_color[15:8]);
      fifo_in.blue = omx_apply(effect, src_pixel.blue, sel_color[7:0]);
    end
  end

  // format is latched per pixel, so a register write never splits a word
  omx_fifo #(
    .WIDTH(PIXW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(src_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_bits),
    .level(fifo_level)
  );

  assign fifo_out = omx_pix_s'(fifo_out_bits);

  // lane packing and the registered pixel bus
  omx_fmt u_fmt (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_out_valid),
    .in_ready(fifo_out_ready),
    .in_pix(fifo_out),
    .out_valid(pixel_out_valid),
    .out_ready(pixel_out_ready),
    .out_data(pixel_out),
    .out_chroma_v(pixel_out_chroma_v)
  );

  // register file next values; reads answer one cycle after the strobe
  always_comb begin
    next_out_ctrl = out_ctrl;
    next_effect_sel = effect_sel;
    next_color = color;
    next_last_code = push ? ovl_code : last_code;
    next_reg_rdata = reg_rdata;
    if (reg_wr) begin
      if (reg_addr == `OMX_OFF_OUT_CTRL) begin
        next_out_ctrl = reg_wdata;
      end else if (reg_addr == `OMX_OFF_EFFECT) begin
        next_effect_sel = reg_wdata;
      end else if (omx_is_color(reg_addr)) begin
        next_color[omx_color_idx(reg_addr)] = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == `OMX_OFF_OUT_CTRL) begin
        next_reg_rdata = out_ctrl;
      end else if (reg_addr == `OMX_OFF_EFFECT) begin
        next_reg_rdata = effect_sel;
      end else if (omx_is_color(reg_addr)) begin
        next_reg_rdata = color[omx_color_idx(reg_addr)];
      end else if (reg_addr == `OMX_OFF_STATUS) begin
        next_reg_rdata = {last_code, 6'(fifo_level)};
      end else begin
        next_reg_rdata = 8'h00; // unmapped index reads zero
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_ctrl <= `OMX_RST_OUT_CTRL;
      effect_sel <= `OMX_RST_EFFECT;
      for (int i = 0; i < `OMX_COLOR_BYTES; i++) begin
        color[i] <= `OMX_RST_COLOR;
      end
      last_code <= 2'b00;
      reg_rdata <= 8'h00;
    end else begin
      out_ctrl <= next_out_ctrl;
      effect_sel <= next_effect_sel;
      color <= next_color;
      last_code <= next_last_code;
      reg_rdata <= next_reg_rdata;
    end
  end

  // checks run on the pixel clock and rest while reset is held
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_pass_through: assert property (push && ovl_code == 2'b00 |->
    fifo_in.red == src_pixel.red && fifo_in.green == src_pixel.green && fifo_in.blue == src_pixel.blue)
    else $error("code 00 changed the pixel");

  a_color_two_replace: assert property (push && ovl_code == 2'b10 && effect_sel[1:0] == 2'b00 |->
    {fifo_in.red, fifo_in.green, fifo_in.blue} == {color[3], color[4], color[5]})
    else $error("code 10 did not show colour two");

  a_color_one_replace: assert property (push && ovl_code == 2'b01 && effect_sel[1:0] == 2'b00 |->
    {fifo_in.red, fifo_in.green, fifo_in.blue} == {color[0], color[1], color[2]})
    else $error("code 01 did not show colour one");

  a_color_three_replace: assert property (push && ovl_code == 2'b11 && effect_sel[1:0] == 2'b00 |->
    {fifo_in.red, fifo_in.green, fifo_in.blue} == {color[6], color[7], color[8]})
    else $error("code 11 did not show colour three");

  // register file: writes land next cycle, reads answer one cycle after the strobe
  a_color_readback: assert property (reg_wr && reg_addr == `OMX_OFF_COLOR_LAST ##2
    reg_rd && reg_addr == `OMX_OFF_COLOR_LAST && !$past(reg_wr) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("colour byte readback mismatch");

  a_color_write: assert property (reg_wr && omx_is_color(reg_addr) |=>
    color[$past(omx_color_idx(reg_addr))] == $past(reg_wdata))
    else $error("colour byte write lost");

  a_effect_write: assert property (reg_wr && reg_addr == `OMX_OFF_EFFECT |=>
    effect_sel == $past(reg_wdata))
    else $error("effect register write lost");

  a_regs_hold: assert property (!reg_wr |=> $stable(out_ctrl) && $stable(effect_sel))
    else $error("control register changed without a write");

  a_unmapped_read: assert property (reg_rd && !omx_is_color(reg_addr) && reg_addr != `OMX_OFF_OUT_CTRL
    && reg_addr != `OMX_OFF_EFFECT && reg_addr != `OMX_OFF_STATUS |=> reg_rdata == 8'h00)
    else $error("unmapped index did not read zero");

  a_status_read: assert property (reg_rd && reg_addr == `OMX_OFF_STATUS |=>
    reg_rdata == {$past(last_code), 6'($past(fifo_level))})
    else $error("status read wrong");

  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  a_effect_and: assert property (push && ovl_code == 2'b01 && effect_sel[1:0] == 2'b01 |->
    fifo_in.blue == (src_pixel.blue & color[2]))
    else $error("and effect wrong");

  a_effect_or: assert property (push && ovl_code == 2'b11 && effect_sel[1:0] == 2'b10 |->
    fifo_in.red == (src_pixel.red | color[6]))
    else $error("or effect wrong");

  a_effect_xor: assert property (push && ovl_code == 2'b01 && effect_sel[1:0] == 2'b11 |->
    fifo_in.green == (src_pixel.green ^ color[1]))
    else $error("xor effect wrong");

  a_xor_white: assert property (push && ovl_code != 2'b00 && effect_sel[1:0] == 2'b11
    && sel_color == 24'hFF_FFFF |-> {fifo_in.red, fifo_in.green, fifo_in.blue}
    == ~{src_pixel.red, src_pixel.green, src_pixel.blue})
    else $error("xor white did not invert");

  a_yuv_untouched: assert property (push |-> fifo_in.luma == src_pixel.luma
    && fifo_in.chroma == src_pixel.chroma)
    else $error("yuv sample altered");

  a_format_bit: assert property (reg_wr && reg_addr == `OMX_OFF_OUT_CTRL |=>
    digital_format_select == $past(reg_wdata[`OMX_FMT_BIT]))
    else $error("format bit not applied");

  a_format_stored: assert property (push |->
    (fifo_in.fmt == OMX_FMT_YUV422) == digital_format_select)
    else $error("pixel tagged with the wrong format");

  a_chroma_tag: assert property (push |-> fifo_in.chroma_is_v == src_pixel.chroma_is_v)
    else $error("chroma tag altered");

  // flow control and the status snapshot
  a_stall_source: assert property (src_valid && !src_ready |-> fifo_level == LW'(FIFO_DEPTH))
    else $error("source stalled with room in fifo");

  a_ready_with_room: assert property (fifo_level != LW'(FIFO_DEPTH) |-> src_ready)
    else $error("source refused with room in fifo");

  a_empty_ready: assert property (fifo_level == '0 |-> src_ready && !fifo_out_valid)
    else $error("empty fifo refused or offered a word");

  a_last_code: assert property (push |=> last_code == $past(ovl_code))
    else $error("status code not the one taken");

  // main scenarios worth seeing
  c_overlay_push: cover property (push && ovl_code != 2'b00);
  c_status_read: cover property (reg_rd && reg_addr == `OMX_OFF_STATUS);
  c_yuv_push: cover property (push && out_ctrl[7] ##[1:40] pixel_out_valid && pixel_out_ready);
  c_fifo_full: cover property (src_valid && !src_ready);
  c_xor_effect: cover property (push && effect_sel[1:0] == 2'b11 && ovl_code == 2'b11);

endmodule // omx_mixer

// ==== sim/omx_osd_model.sv ====
// stands in for the external osd chip that drives the two overlay pins
module omx_osd_model import omx_pkg::*; (
  input wire logic clk,
  input wire logic req_valid,
  input wire logic [1:0] req_code,
  output logic overlay_select_hi,
  output logic overlay_select_lo
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] junk;

  // pins carry no meaning between pixels, so they churn instead of holding the last code
  always @(posedge clk) begin
    junk <= ~junk;
  end

  initial begin
    junk = 2'h1;
  end

  // code rides with its pixel and changes on the same edge as the pixel; 00 when no overlay is wanted
  assign {overlay_select_hi, overlay_select_lo} = req_valid ? req_code : junk;
endmodule // omx_osd_model

// ==== sim/tb.sv ====
module tb import omx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int FD = 4;

  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

  logic clk;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic src_valid = 1'b0;
  logic src_ready;
  omx_src_s src_pixel = '0;
  logic ov_hi, ov_lo;
  logic pixel_out_valid;
  logic pixel_out_ready = 1'b0;
  logic [15:0] pixel_out;
  logic pixel_out_chroma_v, digital_format_select;
  logic req_valid = 1'b0;
  logic [1:0] req_code = 2'h0;
  logic stall = 1'b1;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  logic [23:0] col[3] = '{24'h00_0000, 24'h00_0000, 24'h00_0000};
  logic [1:0] fx = 2'h0;
  logic yuv = 1'b0;
  logic [7:0] cb;

  omx_mixer #(.FIFO_DEPTH(FD)) u_omx_mixer (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .src_valid(src_valid),
    .src_ready(src_ready), .src_pixel(src_pixel), .overlay_select_hi(ov_hi), .overlay_select_lo(ov_lo),
    .pixel_out_valid(pixel_out_valid), .pixel_out_ready(pixel_out_ready), .pixel_out(pixel_out),
    .pixel_out_chroma_v(pixel_out_chroma_v), .digital_format_select(digital_format_select));

  omx_osd_model u_omx_osd_model (.clk(clk), .req_valid(req_valid), .req_code(req_code),
    .overlay_select_hi(ov_hi), .overlay_select_lo(ov_lo));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // expected word: {check tag, tag, bus}; overlay on full 8-bit channels, then 565 packing
  function automatic logic [17:0] expect_of(omx_src_s p, logic [1:0] code);
    logic [23:0] s, c, r;
    s = {p.red, p.green, p.blue};
    c = (code == 2'h0) ? 24'h00_0000 : col[code - 2'h1];
    case (fx)
      2'h0: r = c;
      2'h1: r = s & c;
      2'h2: r = s | c;
      default: r = s ^ c;
    endcase
    if (code == 2'h0) r = s;
    if (yuv) return {1'b1, p.chroma_is_v, p.chroma, p.luma};
    return {2'h0, r[12:10], r[7:3], r[23:19], r[15:13]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, x)
  endtask

  // one pixel with its overlay code; expectation noted at the take edge
  task automatic send(input logic [1:0] code);
    omx_src_s p;
    p = 41'({$urandom, $urandom});
    @(posedge clk);
    src_valid <= 1'b1;
    src_pixel <= p;
    req_valid <= 1'b1;
    req_code <= code;
    @(negedge clk);
    while (src_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    src_valid <= 1'b0;
    req_valid <= 1'b0;
    exp_q.push_back(expect_of(p, code));
  endtask

  task automatic end_of_test;
    $display("counts: mismatches=%0d checked=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // random sink stalls unless a test holds the sink off
  always @(posedge clk) begin
    pixel_out_ready <= !stall && ($urandom_range(3) != 0);
  end

  // checked at the falling edge, before the rising edge that accepts the word
  always @(negedge clk) begin
    if (!sys_rst && pixel_out_valid === 1'b1 && pixel_out_ready) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        e = exp_q.pop_front();
        `CHK(pixel_out, e[15:0])
        if (e[17]) `CHK(pixel_out_chroma_v, e[16])
      end
    end
  end

  initial begin
    void'($urandom(59879));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped index
    for (int a = 8'h14; a <= 8'h1d; a++) rd_chk(8'(a), 8'h00);
    rd_chk(8'h08, 8'h00);
    wr(8'h40, 8'h5a);
    rd_chk(8'h40, 8'h00);
    `CHK(digital_format_select, 1'b0)
    $display("test reset_values done");
    stall <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      cb = 8'($urandom);
      wr(8'(8'h15 + k), cb);
      rd_chk(8'(8'h15 + k), cb);
      col[k / 3][8 * (2 - k % 3) +: 8] = cb;
    end
    $display("test colours done");
    // every effect against every code, rgb565 out
    for (int f = 0; f < 4; f++) begin
      fx = 2'(f);
      wr(8'h14, {6'h00, fx});
      for (int i = 0; i < 16; i++) send(2'(i));
    end
    $display("test effects done");
    // xor with white gives a negative image
    for (int k = 0; k < 3; k++) wr(8'(8'h15 + k), 8'hff);
    col[0] = 24'hff_ffff;
    fx = 2'h3;
    wr(8'h14, 8'h03);
    repeat (6) send(2'h1);
    // and with black blanks the picture, as a controller would on lost lock
    for (int k = 0; k < 3; k++) wr(8'(8'h18 + k), 8'h00);
    col[1] = 24'h00_0000;
    fx = 2'h1;
    wr(8'h14, 8'h01);
    repeat (6) send(2'h2);
    $display("test negative_and_blank done");
    // yuv bus ignores the overlay code entirely
    wr(8'h08, 8'h80);
    yuv = 1'b1;
    rd_chk(8'h08, 8'h80);
    `CHK(digital_format_select, 1'b1)
    for (int i = 0; i < 16; i++) send(2'(i));
    $display("test yuv done");
    // hold the sink off and fill until the source is refused
    stall <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    while (src_ready === 1'b1) begin
      send(2'h2);
      @(negedge clk);
    end
    `CHK(src_ready, 1'b0)
    rd_chk(8'h30, {2'h2, 6'(FD)});
    stall <= 1'b0;
    for (int t = 0; t < 400 && exp_q.size() != 0; t++) @(negedge clk);
    `CHK(exp_q.size(), 0)
    $display("test fill_drain done");
    end_of_test;
  end

  // the whole run needs a few hundred cycles; the limit sits at 6250 cycles
  initial begin
    #50000;
    n_mismatch++;
    end_of_test;
  end
endmodule // tb
